// file: rtl/bdr_params.svh
// constants of the branch decode and resolve block
// assumes the standard 32-bit instruction word layout
`ifndef BDR_PARAMS_SVH
`define BDR_PARAMS_SVH

`define BDR_OP_HI            31
`define BDR_OP_LO            26
`define BDR_SRC1_HI          25
`define BDR_SRC1_LO          21
`define BDR_SRC2_HI          20
`define BDR_SRC2_LO          16
`define BDR_IMM_HI           15
`define BDR_IMM_EXT          14
`define BDR_IMM_LO           0
`define BDR_FUNCT_HI         5
`define BDR_FUNCT_LO         0
`define BDR_SIGN_BIT         31

`define BDR_OP_SPECIAL       6'h00
`define BDR_OP_REGIMM        6'h01
`define BDR_OP_UNEQUAL       6'h05
`define BDR_OP_UNEQUAL_LK    6'h15
`define BDR_OP_NONPOS_LK     6'h16
`define BDR_FUNCT_BREAK      6'h0D

`define BDR_SUB_NEG          5'h00
`define BDR_SUB_NEG_LK       5'h02
`define BDR_SUB_NEG_LINK     5'h10
`define BDR_SUB_NEG_LINK_LK  5'h12
`define BDR_SRC2_ZERO        5'h00

`define BDR_LINK_REG         5'h1F
`define BDR_LINK_REG_RST     5'h00
`define BDR_SLOT_OFFSET      32'h0000_0004
`define BDR_LINK_OFFSET      32'h0000_0008
`define BDR_IMM_SHIFT        2
`define BDR_ZERO_WORD        32'h0000_0000

`endif

// file: rtl/bdr_pkg.sv
// types of the branch decode and resolve block
// assumes nothing of its surroundings
package bdr_pkg;

    typedef enum logic [3:0] {
        BDR_NONE          = 4'b0000,
        BDR_NONPOS_LK     = 4'b0001,
        BDR_NEG           = 4'b0010,
        BDR_NEG_LINK      = 4'b0011,
        BDR_NEG_LINK_LK   = 4'b0100,
        BDR_NEG_LK        = 4'b0101,
        BDR_UNEQUAL       = 4'b0110,
        BDR_UNEQUAL_LK    = 4'b0111,
        BDR_BREAK         = 4'b1000
    } bdr_kind_t;

endpackage

// file: rtl/bdr_branch_unit.sv
// branch decode and resolve for one group of conditional branches and
// the breakpoint trap; effects appear one clock after the instruction.
// assumes the pipeline presents one instruction per valid cycle with its
// address and both register operands already read.
//
// Functional notes
// RULE1 - target is delay-slot address plus sign-extended offset times four
// RULE2 - opcode 010110 with second field 00000: taken if negative or zero
// RULE3 - regimm 000001 sub-code 00000: taken only when source sign bit set
// RULE4 - sub-code 10000 links r31 with address plus 8, taken or not
// RULE5 - sub-code 10010 links, branches if negative, kills slot if untaken
// RULE6 - sub-code 00010 tests sign bit and never writes a link
// RULE7 - every likely form not taken nullifies its delay slot
// RULE8 - condition sampled in branch cycle, redirect issued the next cycle
// RULE9 - unequal forms compare full words; likely one nullifies when equal
// RULE10 - source r31 on a linking branch is accepted without any trap
// RULE11 - breakpoint raises exception at once with no other effect; here break_exc_out is registered and rises one clock later
// RULE12 - trap code is not forwarded; exception pc names the trap word
// RULE13 - fields: opcode 31..26, sources 25..21 and 20..16, offset 15..0
`timescale 1ns/1ns
`default_nettype none
`include "bdr_params.svh"

module bdr_branch_unit
    import bdr_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        instr_valid_in,
    input  wire logic [31:0] instr_in,
    input  wire logic [31:0] instr_pc_in,
    input  wire logic [31:0] first_source_reg_in,
    input  wire logic [31:0] second_source_reg_in,
    output logic             redirect_out,
    output logic [31:0]      redirect_pc_out,
    output logic             nullify_slot_out,
    output logic             link_we_out,
    output logic [4:0]       link_reg_out,
    output logic [31:0]      link_data_out,
    output logic             break_exc_out,
    output logic [31:0]      debug_return_pc_out
);

    ////////////////////////////////////////////////////////////////////////
    // field extraction
    logic [5:0]  opcode;
    logic [4:0]  sub_field;
    logic [15:0] imm_field;
    logic [5:0]  funct_field;

    // RULE13 field layout
    assign opcode      = instr_in[`BDR_OP_HI:`BDR_OP_LO];
    assign sub_field   = instr_in[`BDR_SRC2_HI:`BDR_SRC2_LO];
    assign imm_field   = instr_in[`BDR_IMM_HI:`BDR_IMM_LO];
    assign funct_field = instr_in[`BDR_FUNCT_HI:`BDR_FUNCT_LO];

    ////////////////////////////////////////////////////////////////////////
    // decode
    bdr_kind_t kind;

    always_comb begin
        kind = BDR_NONE;
        if (instr_valid_in) begin
            unique case (opcode)
                // RULE2 nonpositive likely decode
                `BDR_OP_NONPOS_LK: begin
                    if (sub_field == `BDR_SRC2_ZERO) begin
                        kind = BDR_NONPOS_LK;
                    end
                end
                // RULE3 regimm sub-codes
                `BDR_OP_REGIMM: begin
                    unique case (sub_field)
                        `BDR_SUB_NEG:         kind = BDR_NEG;
                        `BDR_SUB_NEG_LINK:    kind = BDR_NEG_LINK;
                        `BDR_SUB_NEG_LINK_LK: kind = BDR_NEG_LINK_LK;
                        `BDR_SUB_NEG_LK:      kind = BDR_NEG_LK;
                        default:              kind = BDR_NONE;
                    endcase
                end
                `BDR_OP_UNEQUAL:    kind = BDR_UNEQUAL;
                `BDR_OP_UNEQUAL_LK: kind = BDR_UNEQUAL_LK;
                `BDR_OP_SPECIAL: begin
                    if (funct_field == `BDR_FUNCT_BREAK) begin
                        kind = BDR_BREAK;
                    end
                end
                // other opcodes belong to other decoders
                default: kind = BDR_NONE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // condition, target and link value, all formed in the branch cycle
    logic        src_negative;
    logic        src_zero;
    logic        srcs_differ;
    logic        cond;
    logic        is_likely;
    logic        is_link;
    logic        is_branch;
    logic [31:0] slot_pc;
    logic [31:0] target;
    logic [31:0] link_value;

    assign src_negative = first_source_reg_in[`BDR_SIGN_BIT];
    assign src_zero     = (first_source_reg_in == `BDR_ZERO_WORD);
    // RULE9 full word compare
    assign srcs_differ  = (first_source_reg_in != second_source_reg_in);

    always_comb begin
        cond      = 1'b0;
        is_likely = 1'b0;
        is_link   = 1'b0;
        is_branch = 1'b1;
        unique case (kind)
            // RULE2 negative or zero
            BDR_NONPOS_LK: begin
                cond      = src_negative | src_zero;
                is_likely = 1'b1;
            end
            // RULE3 sign bit only
            BDR_NEG: cond = src_negative;
            // RULE4 link regardless of outcome
            BDR_NEG_LINK: begin
                cond    = src_negative;
                is_link = 1'b1;
            end
            // RULE5 link and likely
            BDR_NEG_LINK_LK: begin
                cond      = src_negative;
                is_link   = 1'b1;
                is_likely = 1'b1;
            end
            // RULE6 likely, no link
            BDR_NEG_LK: begin
                cond      = src_negative;
                is_likely = 1'b1;
            end
            BDR_UNEQUAL: cond = srcs_differ;
            BDR_UNEQUAL_LK: begin
                cond      = srcs_differ;
                is_likely = 1'b1;
            end
            // RULE11 trap is no branch
            BDR_BREAK: is_branch = 1'b0;
            BDR_NONE:  is_branch = 1'b0;
        endcase
    end

    // RULE1 offset shifted by two, sign extended, added to slot address
    assign slot_pc    = instr_pc_in + `BDR_SLOT_OFFSET;
    assign target     = slot_pc + {{`BDR_IMM_EXT{imm_field[`BDR_IMM_HI]}},
                                   imm_field, {`BDR_IMM_SHIFT{1'b0}}};
    assign link_value = instr_pc_in + `BDR_LINK_OFFSET;

    ////////////////////////////////////////////////////////////////////////
    // redirect, one cycle after the branch so the delay slot still issues
    // RULE8 redirect registered
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            redirect_out    <= 1'b0;
            redirect_pc_out <= `BDR_ZERO_WORD;
        end else begin
            redirect_out    <= is_branch & cond;
            redirect_pc_out <= target;
        end
    end

    // RULE7 nullify untaken likely slot
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nullify_slot_out <= 1'b0;
        end else begin
            nullify_slot_out <= is_likely & ~cond;
        end
    end

    // RULE10 source register is not checked against the link register,
    // so a restart hazard is left to software rather than trapped
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            link_we_out   <= 1'b0;
            link_reg_out  <= `BDR_LINK_REG_RST;
            link_data_out <= `BDR_ZERO_WORD;
        end else begin
            link_we_out   <= is_link;
            link_reg_out  <= `BDR_LINK_REG;
            link_data_out <= link_value;
        end
    end

    // RULE12 only the trap address leaves; the code field has no path out
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            break_exc_out       <= 1'b0;
            debug_return_pc_out <= `BDR_ZERO_WORD;
        end else begin
            break_exc_out <= (kind == BDR_BREAK);
            if (kind == BDR_BREAK) begin
                debug_return_pc_out <= instr_pc_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_target;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        redirect_out |-> redirect_pc_out == $past(instr_pc_in) + 32'h4
            + {{14{$past(instr_in[15])}}, $past(instr_in[15:0]), 2'b00};
    endproperty
    a_target: assert property (p_target) // RULE1
        else $error("branch target wrong");

    property p_nonpos;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (instr_valid_in && instr_in[31:26] == 6'h16
         && instr_in[20:16] == 5'h00)
        |=> redirect_out == ($past(first_source_reg_in[31])
                             || $past(first_source_reg_in) == 32'h0);
    endproperty
    a_nonpos: assert property (p_nonpos) // RULE2
        else $error("nonpositive likely outcome wrong");

    property p_neg;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (instr_valid_in && instr_in[31:26] == 6'h01
         && instr_in[20:16] == 5'h00)
        |=> redirect_out == $past(first_source_reg_in[31]) && !link_we_out;
    endproperty
    a_neg: assert property (p_neg) // RULE3
        else $error("negative branch outcome wrong");

    property p_link;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (instr_valid_in && instr_in[31:26] == 6'h01
         && instr_in[20:16] == 5'h10)
        |=> link_we_out && link_reg_out == 5'h1F
            && link_data_out == $past(instr_pc_in) + 32'h8;
    endproperty
    a_link: assert property (p_link) // RULE4
        else $error("link not written");

    property p_link_likely;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (instr_valid_in && instr_in[31:26] == 6'h01
         && instr_in[20:16] == 5'h12 && !first_source_reg_in[31])
        |=> link_we_out && nullify_slot_out && !redirect_out;
    endproperty
    a_link_likely: assert property (p_link_likely) // RULE5
        else $error("linking likely untaken wrong");

    property p_no_link_likely;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (instr_valid_in && instr_in[31:26] == 6'h01
         && instr_in[20:16] == 5'h02)
        |=> !link_we_out && redirect_out == $past(first_source_reg_in[31]);
    endproperty
    a_no_link_likely: assert property (p_no_link_likely) // RULE6
        else $error("negative likely wrote link");

    property p_nullify_excl;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        nullify_slot_out |-> !redirect_out && !break_exc_out;
    endproperty
    a_nullify_excl: assert property (p_nullify_excl) // RULE7
        else $error("nullify with taken branch");

    property p_unequal;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (instr_valid_in && instr_in[31:26] == 6'h15)
        |=> redirect_out == $past(first_source_reg_in != second_source_reg_in)
            && nullify_slot_out == !redirect_out;
    endproperty
    a_unequal: assert property (p_unequal) // RULE9
        else $error("unequal likely outcome wrong");

    property p_idle;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        !instr_valid_in |=> !redirect_out && !link_we_out && !break_exc_out;
    endproperty
    a_idle: assert property (p_idle) // RULE8
        else $error("effect without instruction");

    property p_break;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        break_exc_out |-> !redirect_out && !link_we_out && !nullify_slot_out
            && debug_return_pc_out == $past(instr_pc_in);
    endproperty
    a_break: assert property (p_break) // RULE11
        else $error("breakpoint had side effects");

    property p_link_r31;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (instr_valid_in && instr_in[31:21] == 11'h03F
         && instr_in[20:16] == 5'h10)
        |=> link_we_out && !break_exc_out;
    endproperty
    a_link_r31: assert property (p_link_r31) // RULE10
        else $error("link from r31 source refused");

    property p_dpc_hold;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        !break_exc_out |-> $stable(debug_return_pc_out);
    endproperty
    a_dpc_hold: assert property (p_dpc_hold) // RULE12
        else $error("trap address changed without trap");

endmodule

`default_nettype wire

// file: testbench/bdr_pipe_model.sv
// far-side model: fetch pc and register file fed by the branch unit
// assumes registered one-cycle pulses from bdr_branch_unit
`timescale 1ns/1ns
`default_nettype none
module bdr_pipe_model (
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        redirect_in,
    input  wire logic [31:0] redirect_pc_in,
    input  wire logic        link_we_in,
    input  wire logic [4:0]  link_reg_in,
    input  wire logic [31:0] link_data_in,
    output logic      [31:0] fetch_pc_out,
    output logic      [31:0] r31_out
);
    logic [31:0] regs_q [32];

    assign r31_out = regs_q[31];

    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            fetch_pc_out <= 32'h0000_0000;
        end else if (redirect_in) begin
            fetch_pc_out <= redirect_pc_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (link_we_in) begin
            regs_q[link_reg_in] <= link_data_in;
        end
    end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for bdr_branch_unit beside a pipeline model
// assumes a 50 MHz core clock and answers one cycle after each request
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        core_clk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        valid = 1'b0;
    logic [31:0] instr = 32'h0;
    logic [31:0] pc = 32'h0;
    logic [31:0] src1_v = 32'h0;
    logic [31:0] src2_v = 32'h0;
    logic        redir, nul, lwe, brk;
    logic [4:0]  lreg;
    logic [31:0] rpc, ldat, dpc, fpc, r31;
    int          fail_count = 0;
    int          num_checks = 0;
    int          cycles = 0;

    initial begin
        forever #10 core_clk_in = ~core_clk_in;
    end

    bdr_branch_unit DUT (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .instr_valid_in(valid), .instr_in(instr), .instr_pc_in(pc),
        .first_source_reg_in(src1_v), .second_source_reg_in(src2_v),
        .redirect_out(redir), .redirect_pc_out(rpc),
        .nullify_slot_out(nul), .link_we_out(lwe), .link_reg_out(lreg),
        .link_data_out(ldat), .break_exc_out(brk),
        .debug_return_pc_out(dpc)
    );

    bdr_pipe_model pipe (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .redirect_in(redir), .redirect_pc_in(rpc), .link_we_in(lwe),
        .link_reg_in(lreg), .link_data_in(ldat),
        .fetch_pc_out(fpc), .r31_out(r31)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] ex, got);
        num_checks++;
        if (got !== ex) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // e: redirect, nullify, link, break from msb down
    task automatic go(input logic [31:0] i, p, a, b,
                      input logic [3:0] e);
        logic [31:0] tgt;
        tgt = p + 32'h4 + {{14{i[15]}}, i[15:0], 2'b00};
        @(posedge core_clk_in);
        valid <= 1'b1;
        instr <= i;
        pc <= p;
        src1_v <= a;
        src2_v <= b;
        @(posedge core_clk_in);
        valid <= 1'b0;
        @(negedge core_clk_in);
        chk("redirect", 32'(e[3]), 32'(redir));
        chk("nullify", 32'(e[2]), 32'(nul));
        chk("link_we", 32'(e[1]), 32'(lwe));
        chk("break", 32'(e[0]), 32'(brk));
        if (e[3]) chk("target", tgt, rpc);
        if (e[1]) chk("link", p + 32'h8, ldat);
        if (e[1]) chk("link_reg", 32'h1F, 32'(lreg));
        if (e[0]) chk("debug_pc", p, dpc);
    endtask

    task automatic t_negative;
        go(32'h0400_FFFF, 32'h100, 32'h8000_0000, 32'h0, 4'h8);
        go(32'h0400_8000, 32'h4_0000, 32'h8000_0001, 32'h0, 4'h8);
        go(32'h0400_7FFF, 32'h100, 32'h7FFF_FFFF, 32'h0, 4'h0);
        go(32'h0400_7FFF, 32'h100, 32'h0, 32'h0, 4'h0);
        go(32'h0401_0001, 32'h100, 32'h0, 32'h0, 4'h0);
        $display("test negative done");
    endtask

    task automatic t_linking;
        go(32'h07F0_0003, 32'h100, 32'h8000_0000, 32'h0, 4'hA);
        @(negedge core_clk_in);
        chk("fetch_pc", 32'h110, fpc);
        chk("r31", 32'h108, r31);
        go(32'h0610_0000, 32'h300, 32'h1, 32'h0, 4'h2);
        go(32'h0612_0002, 32'h300, 32'h5, 32'h0, 4'h6);
        go(32'h0612_0002, 32'h300, 32'hF000_0000, 32'h0, 4'hA);
        go(32'h0402_0001, 32'h300, 32'h1, 32'h0, 4'h4);
        go(32'h0402_0001, 32'h300, 32'h8000_0000, 32'h0, 4'h8);
        $display("test linking done");
    endtask

    task automatic t_compare;
        go(32'h5800_0004, 32'h40, 32'h0, 32'h0, 4'h8);
        go(32'h5800_0004, 32'h40, 32'h8000_0000, 32'h0, 4'h8);
        go(32'h5800_0004, 32'h40, 32'h1, 32'h0, 4'h4);
        go(32'h5801_0004, 32'h40, 32'h0, 32'h0, 4'h0);
        go(32'h1422_0010, 32'h40, 32'h1, 32'h1, 4'h0);
        go(32'h1422_0010, 32'h40, 32'h8000_0000, 32'h8000_0001, 4'h8);
        go(32'h5422_0010, 32'h40, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 4'h4);
        go(32'h5422_0010, 32'h40, 32'h0, 32'h1, 4'h8);
        $display("test compare done");
    endtask

    task automatic t_break;
        go(32'h03FF_FFCD, 32'h200, 32'h8000_0000, 32'h1, 4'h1);
        go(32'h0000_0020, 32'h208, 32'h0, 32'h0, 4'h0);
        chk("debug_pc_hold", 32'h200, dpc);
        go(32'h0000_000D, 32'h204, 32'h0, 32'h0, 4'h1);
        $display("test break done");
    endtask

    // mid-run reset clears held trap address; first request right after
    task automatic t_reset;
        @(posedge core_clk_in);
        rst_n_in <= 1'b0;
        @(negedge core_clk_in);
        chk("reset_debug_pc", 32'h0, dpc);
        chk("reset_link_reg", 32'h0, 32'(lreg));
        @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        go(32'h0000_000D, 32'h300, 32'h0, 32'h0, 4'h1);
        $display("test reset done");
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge core_clk_in);
        @(negedge core_clk_in);
        chk("reset_pulses", 32'h0, 32'({redir, nul, lwe, brk}));
        chk("reset_link_reg", 32'h0, 32'(lreg));
        chk("reset_redirect_pc", 32'h0, rpc);
        chk("reset_link_data", 32'h0, ldat);
        chk("reset_debug_pc", 32'h0, dpc);
        @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        t_negative();
        t_linking();
        t_compare();
        t_break();
        t_reset();
        end_sim();
    end

    // run needs under 100 cycles; a hang is cut well after that
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            fail_count++;
            end_sim();
        end
    end
endmodule
`default_nettype wire
